/* File: cpu_clock_generation.sv */
`timescale 1ns/10ps
// CPU clock generation selector: prescaler, direct drive and digital PLL
module cpu_clock_generation (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Oscillator and strap pins
	input  wire logic       osc_in,
	input  wire logic [2:0] clock_config_pins,
	input  wire logic       emulation_mode,
	// Software reload of the reset latch (same clock domain)
	input  wire logic [7:0] reset_config_high,
	input  wire logic       latch_reload,
	// Clock outputs and status
	output logic            cpu_clk,
	output logic            cpu_half_tick,
	output logic            pll_enable,
	output logic [2:0]      clock_mode_select,
	output logic            config_valid
);
	import clock_gen_pkg::*;

	logic [4:0]  pins_s;
	logic        osc_d_reg;
	logic [1:0]  startup_reg;
	logic [1:0]  startup_next;
	logic [2:0]  mode_next;
	logic [3:0]  trans_reg;
	logic [3:0]  trans_next;
	logic [7:0]  tog_reg;
	logic [7:0]  tog_next;
	logic [15:0] acc_reg;
	logic [15:0] inc_reg;
	logic [15:0] inc_next;
	logic        cpu_next;

	pin_sync #(.WIDTH(5)) u_sync (
		.clk          (clk),
		.rst_n        (rst_n),
		.pin_in       ({emulation_mode, osc_in, clock_config_pins}),
		.pin_sync_out (pins_s)
	);

	wire       emu_s      = pins_s[4];
	wire       osc_s      = pins_s[3];
	wire [2:0] cfg_s      = pins_s[2:0];
	wire       osc_edge   = osc_s ^ osc_d_reg;
	wire       osc_rise   = osc_s & ~osc_d_reg;
	wire       capture    = !config_valid && (startup_reg == STARTUP_CYCLES);
	// Top pin flips under emulation before it is latched
	wire [2:0] strap_val  = {cfg_s[2] ^ emu_s, cfg_s[1:0]}; // see RQ9
	wire [2:0] reload_val = reset_config_high[CFG_FIELD_HI:CFG_FIELD_LO];
	wire       pll_mode   = is_pll(clock_mode_select); // see RQ6
	wire       prescale   = clock_mode_select == MODE_PRESCALE; // see RQ3
	wire       direct     = clock_mode_select == MODE_DIRECT;
	wire [3:0] win_len    = resync_count(clock_mode_select);
	wire       win_end    = osc_edge && (trans_reg == win_len - 4'h1);
	wire [16:0] acc_sum   = {1'b0, acc_reg} + {1'b0, inc_reg};
	wire       nco_carry  = acc_sum[16];
	// Compare generated half cycles against F per input transition
	wire [8:0] tog_x2     = {tog_reg, 1'b0};
	wire [8:0] target     = 9'(factor_x2(clock_mode_select) * win_len);
	wire       too_slow   = tog_x2 < target;
	wire       too_fast   = tog_x2 > target;

	// Field taken once after reset, then only by explicit reload
	assign startup_next = (startup_reg == STARTUP_CYCLES) ?
		startup_reg : startup_reg + 2'h1;
	assign mode_next = latch_reload ? reload_val :  // see RQ12
		capture ? strap_val : clock_mode_select; // see RQ1, RQ13

	assign trans_next = !pll_mode ? 4'h0 :
		win_end ? 4'h0 : osc_edge ? trans_reg + 4'h1 : trans_reg; // see RQ7
	// Carry on the closing cycle opens the next window, so none is lost
	assign tog_next = !pll_mode ? 8'h00 :
		win_end ? {7'h00, nco_carry} :
		(nco_carry && tog_reg != 8'hFF) ? tog_reg + 8'h01 : tog_reg;

	// One small step per window: frequency slews, never jumps
	assign inc_next = !(pll_mode && win_end) ? inc_reg :
		(too_slow && inc_reg <= INC_MAX - INC_STEP) ? inc_reg + INC_STEP :
		(too_fast && inc_reg >= INC_STEP + INC_STEP) ? inc_reg - INC_STEP :
		inc_reg; // see RQ8

	// Clock is held low until the strap has been taken
	assign cpu_next = !config_valid ? 1'b0 :
		prescale ? cpu_clk ^ osc_rise : // see RQ4, RQ5
		direct   ? osc_s :              // see RQ2
		cpu_clk ^ nco_carry;            // see RQ2, RQ6

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			startup_reg       <= 2'h0;
			config_valid      <= 1'b0;
			clock_mode_select <= MODE_RESET;
			osc_d_reg         <= 1'b0;
		end
		else
		begin
			startup_reg       <= startup_next;
			config_valid      <= config_valid | capture;
			clock_mode_select <= mode_next;
			osc_d_reg         <= osc_s;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trans_reg <= 4'h0;
			tog_reg   <= 8'h00;
			acc_reg   <= 16'h0000;
			inc_reg   <= INC_RESET;
		end
		else
		begin
			trans_reg <= trans_next;
			tog_reg   <= tog_next;
			acc_reg   <= pll_mode ? acc_sum[15:0] : 16'h0000;
			inc_reg   <= inc_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpu_clk       <= 1'b0;
			cpu_half_tick <= 1'b0;
			pll_enable    <= 1'b0;
		end
		else
		begin
			cpu_clk       <= cpu_next;
			cpu_half_tick <= cpu_next ^ cpu_clk; // see RQ5
			pll_enable    <= config_valid && pll_mode; // see RQ6
		end
	end

	property p_strap_capture;
		@(posedge clk) disable iff (!rst_n)
		capture && !latch_reload |=> clock_mode_select == $past(strap_val);
	endproperty
	a_strap_capture: assert property (p_strap_capture) // see RQ1, RQ9
		else $error("strap not latched with emulation inversion");

	property p_hold_cfg;
		@(posedge clk) disable iff (!rst_n)
		config_valid && !latch_reload |=> $stable(clock_mode_select);
	endproperty
	a_hold_cfg: assert property (p_hold_cfg) // see RQ13
		else $error("clock mode changed without reload");

	property p_reload;
		@(posedge clk) disable iff (!rst_n)
		latch_reload |=> clock_mode_select ==
			$past(reset_config_high[CFG_FIELD_HI:CFG_FIELD_LO]);
	endproperty
	a_reload: assert property (p_reload) // see RQ12
		else $error("reload did not take the upper field");

	property p_prescale_rise;
		@(posedge clk) disable iff (!rst_n)
		config_valid && prescale && osc_rise |=> cpu_clk != $past(cpu_clk);
	endproperty
	a_prescale_rise: assert property (p_prescale_rise) // see RQ3, RQ4
		else $error("prescaler missed an input rising edge");

	property p_prescale_hold;
		@(posedge clk) disable iff (!rst_n)
		config_valid && prescale && !osc_rise && !latch_reload
			|=> $stable(cpu_clk);
	endproperty
	a_prescale_hold: assert property (p_prescale_hold) // see RQ4
		else $error("prescaler toggled without input rising edge");

	property p_direct;
		@(posedge clk) disable iff (!rst_n)
		config_valid && direct |=> cpu_clk == $past(osc_s);
	endproperty
	a_direct: assert property (p_direct) // see RQ2
		else $error("direct drive does not follow the input");

	property p_pll_enable;
		@(posedge clk) disable iff (!rst_n)
		config_valid |=> pll_enable == $past(pll_mode);
	endproperty
	a_pll_enable: assert property (p_pll_enable) // see RQ6
		else $error("PLL enable does not match mode");

	property p_window;
		@(posedge clk) disable iff (!rst_n)
		pll_mode && win_end && !latch_reload |=> trans_reg == 4'h0;
	endproperty
	a_window: assert property (p_window) // see RQ7
		else $error("resync window did not restart");

	property p_smooth;
		@(posedge clk) disable iff (!rst_n)
		!win_end |=> $stable(inc_reg);
	endproperty
	a_smooth: assert property (p_smooth) // see RQ8
		else $error("PLL rate moved outside a resync point");

	property p_half_tick;
		@(posedge clk) disable iff (!rst_n)
		cpu_half_tick |-> cpu_clk != $past(cpu_clk);
	endproperty
	a_half_tick: assert property (p_half_tick) // see RQ5
		else $error("half period tick without clock edge");

	property p_tick_every;
		@(posedge clk) disable iff (!rst_n)
		cpu_clk != $past(cpu_clk) |-> cpu_half_tick;
	endproperty
	a_tick_every: assert property (p_tick_every) // see RQ5
		else $error("clock edge without half period tick");

	// Rate may only move by one step at a resync point
	property p_step_bound;
		@(posedge clk) disable iff (!rst_n)
		pll_mode && win_end |=> (inc_reg == $past(inc_reg))
			|| (inc_reg == $past(inc_reg) + INC_STEP)
			|| (inc_reg == $past(inc_reg) - INC_STEP);
	endproperty
	a_step_bound: assert property (p_step_bound) // see RQ8
		else $error("PLL rate jumped by more than one step");

	c_prescale: cover property (@(posedge clk) config_valid && prescale
		&& osc_rise);
	c_pll_win: cover property (@(posedge clk) pll_mode && win_end
		&& too_slow);
	c_reload: cover property (@(posedge clk) config_valid && latch_reload);

endmodule // cpu_clock_generation

/* File: clock_gen_pkg.sv */
// Constants and mode decoding for the CPU clock generation selector
// Overview of operation
// (RQ1) Clock mode comes from a three-bit field taken from three configuration pins.
// (RQ2) CPU clock is input clock times factor 4,3,2,5,1,1.5,2.5; 111 default.
// (RQ3) Field value 001 bypasses the PLL through a divide-by-two prescaler.
// (RQ4) Prescaler output is half the input rate, each phase one input period.
// (RQ5) In prescaler mode one CPU half period equals one input clock period.
// (RQ6) Any multiplying mode enables the PLL and uses its output as CPU clock.
// (RQ7) PLL resynchronises to the input once every F-th input transition.
// (RQ8) Resynchronisation is gradual; CPU frequency never changes abruptly.
// (RQ9) In emulation mode the top configuration pin is inverted before latching.
// (RQ10) Outside source keeps the resulting CPU clock between 10 and 25 MHz.
// (RQ11) Outside source keeps a balanced duty cycle in direct drive mode.
// (RQ12) Software may reload the clock field from the reset config register.
// (RQ13) Field is sampled at end of reset and held stable afterwards.
package clock_gen_pkg;

	localparam logic [2:0] MODE_X4       = 3'h7;
	localparam logic [2:0] MODE_X3       = 3'h6;
	localparam logic [2:0] MODE_X2       = 3'h5;
	localparam logic [2:0] MODE_X5       = 3'h4;
	localparam logic [2:0] MODE_DIRECT   = 3'h3;
	localparam logic [2:0] MODE_X1P5     = 3'h2;
	localparam logic [2:0] MODE_PRESCALE = 3'h1;
	localparam logic [2:0] MODE_X2P5     = 3'h0;
	localparam logic [2:0] MODE_RESET    = MODE_X4;

	// Field position inside the reset config register upper half
	localparam int CFG_FIELD_HI = 7;
	localparam int CFG_FIELD_LO = 5;
	// Cycles the pin synchroniser needs before the field is valid
	localparam logic [1:0] STARTUP_CYCLES = 2'h2;

	// NCO tuning: 16-bit phase, bounded increment, small steps
	localparam logic [15:0] INC_RESET = 16'h2000;
	localparam logic [15:0] INC_STEP  = 16'h0040;
	localparam logic [15:0] INC_MAX   = 16'h8000;

	// Factor times two, so that 1.5 and 2.5 stay integral
	function automatic logic [3:0] factor_x2(input logic [2:0] mode);
		unique case (mode)
			MODE_X4:     factor_x2 = 4'h8;
			MODE_X3:     factor_x2 = 4'h6;
			MODE_X2:     factor_x2 = 4'h4;
			MODE_X5:     factor_x2 = 4'hA;
			MODE_X1P5:   factor_x2 = 4'h3;
			MODE_X2P5:   factor_x2 = 4'h5;
			default:     factor_x2 = 4'h2;
		endcase
	endfunction

	// Input transitions per resync window (F rounded up)
	function automatic logic [3:0] resync_count(input logic [2:0] mode);
		unique case (mode)
			MODE_X4:     resync_count = 4'h4;
			MODE_X3:     resync_count = 4'h3;
			MODE_X2:     resync_count = 4'h2;
			MODE_X5:     resync_count = 4'h5;
			MODE_X1P5:   resync_count = 4'h2;
			MODE_X2P5:   resync_count = 4'h3;
			default:     resync_count = 4'h1;
		endcase
	endfunction

	function automatic logic is_pll(input logic [2:0] mode);
		is_pll = (mode != MODE_DIRECT) && (mode != MODE_PRESCALE);
	endfunction

endpackage

/* File: pin_sync.sv */
`timescale 1ns/10ps
// Two-flop synchroniser for asynchronous pin inputs
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Pins and synchronised copies
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync_out
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg     <= '0;
			pin_sync_out <= '0;
		end
		else
		begin
			meta_reg     <= pin_in;
			pin_sync_out <= meta_reg;
		end
	end

endmodule // pin_sync

/* File: osc_source.sv */
`timescale 1ns/10ps
// Behavioural model of the external oscillator feeding the selector
module osc_source (
	// Clock
	input  wire logic       clk,
	// Half period in system cycles; zero parks the line low
	input  wire logic [7:0] half_cycles,
	// Oscillator pin
	output logic            osc_pin
);
	logic [7:0] count_reg = 8'h00;
	initial osc_pin = 1'b0;
	// Rates picked by the bench keep the scaled CPU clock at or below 6.25 MHz, under the 10 to 25 MHz range
	always @(posedge clk)
	begin
		if (half_cycles === 8'h00)
		begin
			osc_pin   <= 1'b0;
			count_reg <= 8'h00;
		end
		else if (count_reg + 8'h01 >= half_cycles)
		begin
			osc_pin   <= ~osc_pin;
			count_reg <= 8'h00;
		end
		else
			count_reg <= count_reg + 8'h01;
	end
endmodule // osc_source

/* File: cpu_clock_generation_tb_top.sv */
`timescale 1ns/10ps
// Self-checking bench for the CPU clock generation selector
module cpu_clock_generation_tb_top;
	import clock_gen_pkg::*;
	logic       clk      = 1'b0;
	logic       rst_n    = 1'b0;
	logic       osc_in;
	logic [2:0] pins     = 3'h7;
	logic       emu      = 1'b0;
	logic [7:0] cfg_high = 8'h00;
	logic       reload   = 1'b0;
	logic [7:0] half     = 8'h00;
	logic       cpu_clk, tick, pll_en, valid;
	logic [2:0] mode;
	int         err_total   = 0;
	int         check_count = 0;

	osc_source u_osc (.clk(clk), .half_cycles(half), .osc_pin(osc_in));

	cpu_clock_generation u_dut (
		.clk(clk), .rst_n(rst_n), .osc_in(osc_in),
		.clock_config_pins(pins), .emulation_mode(emu),
		.reset_config_high(cfg_high), .latch_reload(reload),
		.cpu_clk(cpu_clk), .cpu_half_tick(tick), .pll_enable(pll_en),
		.clock_mode_select(mode), .config_valid(valid));

	initial
	begin
		forever #5 clk = ~clk;
	end

	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Straps stay stable across release until the capture edge
	task automatic do_reset(logic [2:0] p, logic e, logic [7:0] h);
		@(posedge clk);
		rst_n <= 1'b0;
		pins  <= p;
		emu   <= e;
		half  <= h;
		repeat (4) @(posedge clk);
		#1;
		chk("mode_in_reset", {13'h0, mode}, 16'h0007);
		chk("valid_in_reset", {15'h0, valid}, 16'h0000);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
	endtask

	// Waits for a rising cpu_clk and returns how long it stays high
	task automatic hi_width(output int w);
		int n = 0;
		#1;
		w = 0;
		while (cpu_clk !== 1'b0 && n < 500)
		begin
			@(posedge clk); #1; n++;
		end
		while (cpu_clk !== 1'b1 && n < 500)
		begin
			@(posedge clk); #1; n++;
		end
		chk("half_tick", {15'h0, tick}, 16'h0001);
		while (cpu_clk === 1'b1 && n < 500)
		begin
			@(posedge clk); #1; n++; w++;
		end
	endtask

	task automatic test_straps();
		for (int i = 0; i < 8; i++)
		begin
			do_reset(i[2:0], 1'b0, 8'h00);
			chk("mode", {13'h0, mode}, 16'(i));
			chk("valid", {15'h0, valid}, 16'h0001);
			chk("pll_en", {15'h0, pll_en}, 16'(i != 3 && i != 1));
		end
		$display("test straps done");
	endtask

	task automatic test_emu_reload();
		do_reset(3'h1, 1'b1, 8'h00);
		chk("emu_mode", {13'h0, mode}, 16'h0005);
		@(posedge clk);
		cfg_high <= 8'h60;
		reload   <= 1'b1;
		pins     <= 3'h0;
		@(posedge clk);
		reload <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("reload_mode", {13'h0, mode}, 16'h0003);
		repeat (10) @(posedge clk);
		#1;
		chk("mode_held", {13'h0, mode}, 16'h0003);
		$display("test emulation and reload done");
	endtask

	task automatic test_prescale_direct();
		int w;
		do_reset(3'h1, 1'b0, 8'h08);
		repeat (60) @(posedge clk);
		repeat (2)
		begin
			hi_width(w);
			chk("prescale_high", 16'(w), 16'h0010);
		end
		do_reset(3'h3, 1'b0, 8'h08);
		repeat (60) @(posedge clk);
		hi_width(w);
		chk("direct_high", 16'(w), 16'h0008);
		$display("test prescale and direct done");
	endtask

	// 40-cycle oscillator: x2 toggles every 10 cycles, x1.5 every 13.3
	task automatic test_pll(logic [2:0] m, int lo, int hi);
		int c = 0;
		int w1, w2;
		do_reset(m, 1'b0, 8'h14);
		chk("pll_en_on", {15'h0, pll_en}, 16'h0001);
		repeat (3000) @(posedge clk);
		repeat (800)
		begin
			@(posedge clk); #1;
			if (tick === 1'b1) c++;
		end
		chk("pll_ticks_ok", 16'(c >= lo && c <= hi), 16'h0001);
		hi_width(w1);
		hi_width(w2);
		chk("pll_smooth", 16'(w1 - w2 <= 1 && w2 - w1 <= 1), 16'h0001);
		$display("test pll done");
	endtask

	initial
	begin
		repeat (60000) @(posedge clk);
		err_total++;
		$display("[FAIL] watchdog expected finish seen timeout");
		conclude();
	end

	initial
	begin
		test_straps();
		test_emu_reload();
		test_prescale_direct();
		test_pll(3'h5, 72, 88);
		test_pll(3'h2, 54, 66);
		conclude();
	end
endmodule // cpu_clock_generation_tb_top
